// ===== core/rbx_defines.vh
// constants for the registered octal bus transceiver with scan port
// What this block does
// - A-to-B clock rise stores A bus
// - A-to-B select low passes live A
// - A-to-B select high drives stored A
// - B side driven only while enable high, except in pattern mode
// - B-to-A direction mirrors A-to-B behaviour
// - A side enable is active low
// - bus capture ignores output enable levels
// - both registered outputs may drive together
// - driven B side lets B-to-A store A
// - driven A side lets A-to-B store B
// - test mode inhibits normal bus operation
// - scan use in normal mode changes nothing
// - test mode compresses inputs, generates patterns
// - test logic controlled by four scan pins
// - scan captures on rise, drives on fall
`ifndef RBX_DEFINES_VH
`define RBX_DEFINES_VH

`define RBX_BUS_W 8
`define RBX_IR_W 8
`define RBX_ST_W 4

// scan controller states
`define RBX_ST_RESET 4'h0
`define RBX_ST_IDLE 4'h1
`define RBX_ST_SEL_DR 4'h2
`define RBX_ST_CAP_DR 4'h3
`define RBX_ST_SH_DR 4'h4
`define RBX_ST_EX1_DR 4'h5
`define RBX_ST_PAU_DR 4'h6
`define RBX_ST_EX2_DR 4'h7
`define RBX_ST_UPD_DR 4'h8
`define RBX_ST_SEL_IR 4'h9
`define RBX_ST_CAP_IR 4'hA
`define RBX_ST_SH_IR 4'hB
`define RBX_ST_EX1_IR 4'hC
`define RBX_ST_PAU_IR 4'hD
`define RBX_ST_EX2_IR 4'hE
`define RBX_ST_UPD_IR 4'hF

// instruction codes
`define RBX_IR_BYPASS 8'hFF
`define RBX_IR_SAMPLE 8'h82
`define RBX_IR_COMPRESS 8'h0C
`define RBX_IR_PATTERN 8'h0A
`define RBX_IR_HIGHZ 8'h06
`define RBX_IR_CAPTURE 8'h01

// signature and pattern registers
`define RBX_LFSR_TAPS 8'hB8
`define RBX_GEN_SEED 8'h01
`define RBX_CMP_SEED 8'h00

`endif

// ===== core/rbx_dir.v
// one transfer direction: storage register and live or stored select
`timescale 1ns/1ps
module rbx_dir #(
   parameter W = 8
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire cap_rise,
   input wire inhibit,
   input wire src_sel,
   // data
   input wire [W-1:0] bus_in,
   output wire [W-1:0] stored_q,
   output wire [W-1:0] path_out
);
   reg [W-1:0] store_q;
   reg [W-1:0] store_d;

   always @* begin
      store_d = store_q;
      if (cap_rise && !inhibit) begin
         store_d = bus_in;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         store_q <= {W{1'b0}};
      end else begin
         store_q <= store_d;
      end
   end

   assign stored_q = store_q;
   // live input goes straight through, stored when select high
   assign path_out = src_sel ? store_q : bus_in;
endmodule // rbx_dir

// ===== core/rbx_sig.v
// signature compressor and pattern generator stepped by the scan clock
`timescale 1ns/1ps
`include "rbx_defines.vh"
module rbx_sig #(
   parameter W = 8
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // scan timing
   input wire tck_rise,
   input wire clear,
   // operations
   input wire cmp_step,
   input wire gen_step,
   input wire shift_sig,
   input wire shift_pat,
   input wire shift_in,
   input wire [W-1:0] cmp_data,
   // state
   output wire [W-1:0] sig_q,
   output wire [W-1:0] pat_q
);
   reg [W-1:0] cmp_q;
   reg [W-1:0] cmp_d;
   reg [W-1:0] gen_q;
   reg [W-1:0] gen_d;
   wire [W-1:0] taps;
   wire cmp_fb;
   wire gen_fb;

   assign taps = `RBX_LFSR_TAPS;
   assign cmp_fb = ^(cmp_q & taps);
   assign gen_fb = ^(gen_q & taps);

   always @* begin
      cmp_d = cmp_q;
      gen_d = gen_q;
      if (clear) begin
         cmp_d = `RBX_CMP_SEED;
         gen_d = `RBX_GEN_SEED;
      end else if (tck_rise) begin
         if (cmp_step) begin
            cmp_d = {cmp_q[W-2:0], cmp_fb} ^ cmp_data;
         end else if (shift_sig) begin
            cmp_d = {shift_in, cmp_q[W-1:1]};
         end
         if (gen_step) begin
            gen_d = {gen_q[W-2:0], gen_fb};
         end else if (shift_pat) begin
            gen_d = {shift_in, gen_q[W-1:1]};
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_q <= `RBX_CMP_SEED;
         gen_q <= `RBX_GEN_SEED;
      end else begin
         cmp_q <= cmp_d;
         gen_q <= gen_d;
      end
   end

   assign sig_q = cmp_q;
   assign pat_q = gen_q;
endmodule // rbx_sig

// ===== core/rbx_xcvr.v
// registered octal bus transceiver with four-wire scan control
`timescale 1ns/1ps
`include "rbx_defines.vh"
module rbx_xcvr #(
   parameter W = `RBX_BUS_W,
   parameter IRW = `RBX_IR_W
) (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // a side bus pins
   input wire [W-1:0] a_in,
   output wire [W-1:0] a_out,
   output wire [W-1:0] a_oe,
   // b side bus pins
   input wire [W-1:0] b_in,
   output wire [W-1:0] b_out,
   output wire [W-1:0] b_oe,
   // normal function control
   input wire a_to_b_reg_clock,
   input wire b_to_a_reg_clock,
   input wire a_to_b_source_select,
   input wire b_to_a_source_select,
   input wire b_side_output_enable,
   input wire a_side_output_enable_n,
   // scan port
   input wire tck,
   input wire tms,
   input wire tdi,
   output wire tdo,
   output wire tdo_oe,
   // status
   output wire test_mode
);
   reg [1:0] rst_sync_q;
   wire rst_n;
   reg ab_clk_q;
   reg ba_clk_q;
   reg tck_q;
   wire ab_rise;
   wire ba_rise;
   wire tck_rise;
   wire tck_fall;
   reg [`RBX_ST_W-1:0] st_q;
   reg [`RBX_ST_W-1:0] st_d;
   reg [IRW-1:0] ir_q;
   reg [IRW-1:0] ir_d;
   reg [IRW-1:0] ir_sh_q;
   reg [IRW-1:0] ir_sh_d;
   reg [W-1:0] samp_q;
   reg [W-1:0] samp_d;
   reg byp_q;
   reg byp_d;
   reg tdo_q;
   reg tdo_oe_q;
   reg [W-1:0] pat_out_q;
   reg serial_bit;
   wire in_test;
   wire is_cmp;
   wire is_gen;
   wire run_idle;
   wire sh_dr;
   wire sh_ir;
   wire [W-1:0] ab_stored;
   wire [W-1:0] ba_stored;
   wire [W-1:0] ab_path;
   wire [W-1:0] ba_path;
   wire [W-1:0] sig_val;
   wire [W-1:0] pat_val;

   // reset release through two flops
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // edge detection of sampled clock pins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ab_clk_q <= 1'b0;
         ba_clk_q <= 1'b0;
         tck_q <= 1'b0;
      end else begin
         ab_clk_q <= a_to_b_reg_clock;
         ba_clk_q <= b_to_a_reg_clock;
         tck_q <= tck;
      end
   end
   assign ab_rise = a_to_b_reg_clock & ~ab_clk_q;
   assign ba_rise = b_to_a_reg_clock & ~ba_clk_q;
   assign tck_rise = tck & ~tck_q;
   assign tck_fall = ~tck & tck_q;

   // scan controller, stepped by tms on tck rise
   always @* begin
      st_d = st_q;
      if (tck_rise) begin
         case (st_q)
            `RBX_ST_RESET: st_d = tms ? `RBX_ST_RESET : `RBX_ST_IDLE;
            `RBX_ST_IDLE: st_d = tms ? `RBX_ST_SEL_DR : `RBX_ST_IDLE;
            `RBX_ST_SEL_DR: st_d = tms ? `RBX_ST_SEL_IR : `RBX_ST_CAP_DR;
            `RBX_ST_CAP_DR: st_d = tms ? `RBX_ST_EX1_DR : `RBX_ST_SH_DR;
            `RBX_ST_SH_DR: st_d = tms ? `RBX_ST_EX1_DR : `RBX_ST_SH_DR;
            `RBX_ST_EX1_DR: st_d = tms ? `RBX_ST_UPD_DR : `RBX_ST_PAU_DR;
            `RBX_ST_PAU_DR: st_d = tms ? `RBX_ST_EX2_DR : `RBX_ST_PAU_DR;
            `RBX_ST_EX2_DR: st_d = tms ? `RBX_ST_UPD_DR : `RBX_ST_SH_DR;
            `RBX_ST_UPD_DR: st_d = tms ? `RBX_ST_SEL_DR : `RBX_ST_IDLE;
            `RBX_ST_SEL_IR: st_d = tms ? `RBX_ST_RESET : `RBX_ST_CAP_IR;
            `RBX_ST_CAP_IR: st_d = tms ? `RBX_ST_EX1_IR : `RBX_ST_SH_IR;
            `RBX_ST_SH_IR: st_d = tms ? `RBX_ST_EX1_IR : `RBX_ST_SH_IR;
            `RBX_ST_EX1_IR: st_d = tms ? `RBX_ST_UPD_IR : `RBX_ST_PAU_IR;
            `RBX_ST_PAU_IR: st_d = tms ? `RBX_ST_EX2_IR : `RBX_ST_PAU_IR;
            `RBX_ST_EX2_IR: st_d = tms ? `RBX_ST_UPD_IR : `RBX_ST_SH_IR;
            `RBX_ST_UPD_IR: st_d = tms ? `RBX_ST_SEL_DR : `RBX_ST_IDLE;
            default: st_d = `RBX_ST_RESET;
         endcase
      end
   end

   assign run_idle = (st_q == `RBX_ST_IDLE);
   assign sh_dr = (st_q == `RBX_ST_SH_DR);
   assign sh_ir = (st_q == `RBX_ST_SH_IR);

   // instruction shift and update
   always @* begin
      ir_sh_d = ir_sh_q;
      ir_d = ir_q;
      if (st_q == `RBX_ST_RESET) begin
         ir_d = `RBX_IR_BYPASS;
         ir_sh_d = `RBX_IR_BYPASS;
      end else if (tck_rise) begin
         if (st_q == `RBX_ST_CAP_IR) begin
            ir_sh_d = `RBX_IR_CAPTURE;
         end else if (sh_ir) begin
            ir_sh_d = {tdi, ir_sh_q[IRW-1:1]};
         end else if (st_q == `RBX_ST_UPD_IR) begin
            ir_d = ir_sh_q;
         end
      end
   end

   // only bypass and sample leave normal function running
   assign in_test = (ir_q != `RBX_IR_BYPASS) && (ir_q != `RBX_IR_SAMPLE);
   assign is_cmp = (ir_q == `RBX_IR_COMPRESS);
   assign is_gen = (ir_q == `RBX_IR_PATTERN);

   // sample register and bypass bit
   always @* begin
      samp_d = samp_q;
      byp_d = byp_q;
      if (tck_rise) begin
         if (st_q == `RBX_ST_CAP_DR) begin
            samp_d = a_in;
            byp_d = 1'b0;
         end else if (sh_dr) begin
            samp_d = {tdi, samp_q[W-1:1]};
            byp_d = tdi;
         end
      end
   end

   // serial output source for the selected register
   always @* begin
      serial_bit = byp_q;
      if (sh_ir) begin
         serial_bit = ir_sh_q[0];
      end else if (is_cmp) begin
         serial_bit = sig_val[0];
      end else if (is_gen) begin
         serial_bit = pat_val[0];
      end else if (ir_q == `RBX_IR_SAMPLE) begin
         serial_bit = samp_q[0];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= `RBX_ST_RESET;
         ir_q <= `RBX_IR_BYPASS;
         ir_sh_q <= `RBX_IR_BYPASS;
         samp_q <= {W{1'b0}};
         byp_q <= 1'b0;
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
         pat_out_q <= `RBX_GEN_SEED;
      end else begin
         st_q <= st_d;
         ir_q <= ir_d;
         ir_sh_q <= ir_sh_d;
         samp_q <= samp_d;
         byp_q <= byp_d;
         if (tck_fall) begin
            tdo_q <= serial_bit;
            tdo_oe_q <= sh_dr | sh_ir;
            // pattern reaches the b pins only on a tck fall
            pat_out_q <= pat_val;
         end
      end
   end

   assign tdo = tdo_q;
   assign tdo_oe = tdo_oe_q;
   assign test_mode = in_test;

   // signature and pattern engines run in run-test/idle
   rbx_sig #(
      .W(W)
   ) u_sig (
      .clk(clk),
      .rst_n(rst_n),
      .tck_rise(tck_rise),
      .clear(st_q == `RBX_ST_RESET),
      .cmp_step(is_cmp & run_idle),
      .gen_step(is_gen & run_idle),
      .shift_sig(is_cmp & sh_dr),
      .shift_pat(is_gen & sh_dr),
      .shift_in(tdi),
      .cmp_data(a_in),
      .sig_q(sig_val),
      .pat_q(pat_val)
   );

   // pin inputs carry the resolved wire, so a driven side stores its own drive
   rbx_dir #(
      .W(W)
   ) u_ab (
      .clk(clk),
      .rst_n(rst_n),
      .cap_rise(ab_rise),
      .inhibit(in_test),
      .src_sel(a_to_b_source_select),
      .bus_in(a_in),
      .stored_q(ab_stored),
      .path_out(ab_path)
   );

   rbx_dir #(
      .W(W)
   ) u_ba (
      .clk(clk),
      .rst_n(rst_n),
      .cap_rise(ba_rise),
      .inhibit(in_test),
      .src_sel(b_to_a_source_select),
      .bus_in(b_in),
      .stored_q(ba_stored),
      .path_out(ba_path)
   );

   // drivers: normal function, or pattern on b side in pattern mode
   assign b_out = in_test ? pat_out_q : ab_path;
   assign a_out = in_test ? {W{1'b0}} : ba_path;
   assign b_oe = {W{in_test ? is_gen : b_side_output_enable}};
   assign a_oe = {W{~in_test & ~a_side_output_enable_n}};
endmodule // rbx_xcvr

// ===== bench/rbx_xcvr_chk.sv
// pin-level assertions for the registered bus transceiver
`timescale 1ns/1ps
module rbx_xcvr_chk #(
   parameter W = 8
) (
   // clock and reset
   input wire clk,
   input wire reset_n,
   // bus pins
   input wire [W-1:0] a_in,
   input wire [W-1:0] a_out,
   input wire [W-1:0] a_oe,
   input wire [W-1:0] b_in,
   input wire [W-1:0] b_out,
   input wire [W-1:0] b_oe,
   // normal controls
   input wire a_to_b_reg_clock,
   input wire b_to_a_reg_clock,
   input wire a_to_b_source_select,
   input wire b_to_a_source_select,
   input wire b_side_output_enable,
   input wire a_side_output_enable_n,
   // scan and status
   input wire tck,
   input wire tdo,
   input wire test_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_b_enable: assert property (!test_mode |-> b_oe == {W{b_side_output_enable}})
      else $error("b side enable wrong");
   a_a_enable: assert property (!test_mode |-> a_oe == {W{!a_side_output_enable_n}})
      else $error("a side enable wrong");
   a_live_ab: assert property (!test_mode && !a_to_b_source_select |-> b_out == a_in)
      else $error("live a to b wrong");
   a_live_ba: assert property (!test_mode && !b_to_a_source_select |-> a_out == b_in)
      else $error("live b to a wrong");
   a_store_ab: assert property (!test_mode && a_to_b_reg_clock && !$past(a_to_b_reg_clock) ##1
      !test_mode && a_to_b_source_select |-> b_out == $past(a_in)) else $error("a to b store wrong");
   a_store_ba: assert property (!test_mode && b_to_a_reg_clock && !$past(b_to_a_reg_clock) ##1
      !test_mode && b_to_a_source_select |-> a_out == $past(b_in)) else $error("b to a store wrong");
   a_test_float: assert property (test_mode |-> a_oe == {W{1'b0}})
      else $error("a side driven in test");
   a_tdo_fall: assert property ($changed(tdo) |-> $past(tck, 2) && !$past(tck))
      else $error("tdo moved off a fall");
   a_pat_fall: assert property (test_mode && $past(test_mode) && $changed(b_out) |->
      $past(tck, 2) && !$past(tck)) else $error("pattern moved off a fall");
endmodule // rbx_xcvr_chk

bind rbx_xcvr rbx_xcvr_chk #(.W(W)) u_rbx_xcvr_chk (.*);

// ===== bench/rbx_bus_far.sv
// far-side model of both buses: drives on request, else toggles the last value
`timescale 1ns/1ps
module rbx_bus_far (
   // clock
   input wire clk,
   // design drive
   input wire [7:0] a_out,
   input wire [7:0] a_oe,
   input wire [7:0] b_out,
   input wire [7:0] b_oe,
   // far drive
   input wire a_drv,
   input wire b_drv,
   input wire [7:0] a_val,
   input wire [7:0] b_val,
   // resolved wires
   output wire [7:0] a_in,
   output wire [7:0] b_in
);
   reg [7:0] a_last_q;
   reg [7:0] b_last_q;
   // undriven wire toggles so no stale value survives
   assign a_in = a_oe[0] ? a_out : (a_drv ? a_val : ~a_last_q);
   assign b_in = b_oe[0] ? b_out : (b_drv ? b_val : ~b_last_q);
   always @(posedge clk) begin
      a_last_q <= a_in;
      b_last_q <= b_in;
   end
endmodule // rbx_bus_far

// ===== bench/rbx_xcvr_test.sv
// self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
module rbx_xcvr_test;
   reg clk, reset_n, tck, tms, tdi, a_drv, b_drv;
   reg clk_ab, clk_ba, sel_ab, sel_ba, en_b, en_a_n;
   reg [7:0] a_val, b_val, pat;
   wire [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
   wire tdo, tdo_oe, test_mode;
   integer errors, comparisons, i;

   rbx_xcvr u_rbx_xcvr (.clk(clk), .reset_n(reset_n), .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
      .b_in(b_in), .b_out(b_out), .b_oe(b_oe), .a_to_b_reg_clock(clk_ab), .b_to_a_reg_clock(clk_ba),
      .a_to_b_source_select(sel_ab), .b_to_a_source_select(sel_ba), .b_side_output_enable(en_b),
      .a_side_output_enable_n(en_a_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .test_mode(test_mode));
   rbx_bus_far u_rbx_bus_far (.*);

   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end

   task close_out;
      begin
         $display("errors %0d comparisons %0d", errors, comparisons);
         if (errors == 0 && comparisons > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask

   task check(input [7:0] seen, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task step(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask

   task pulse(input ab, input ba);
      begin
         clk_ab = ab;
         clk_ba = ba;
         step(1);
         clk_ab = 0;
         clk_ba = 0;
         step(1);
      end
   endtask

   task tck_bit(input m, input d);
      begin
         tms = m;
         tdi = d;
         tck = 1;
         step(2);
         tck = 0;
         step(2);
      end
   endtask

   task load_ir(input [7:0] op);
      begin
         repeat (5) tck_bit(1, 0);
         tck_bit(0, 0);
         tck_bit(1, 0);
         tck_bit(1, 0);
         tck_bit(0, 0);
         tck_bit(0, 0);
         for (i = 0; i < 8; i = i + 1) tck_bit(i == 7, op[i]);
         tck_bit(1, 0);
         tck_bit(0, 0);
      end
   endtask

   task t_live;
      begin
         {sel_ab, en_b, en_a_n, a_drv, b_drv} = 5'b01110;
         for (i = 0; i < 3; i = i + 1) begin
            a_val = 8'h5a ^ (i * 8'h33);
            #1;
            check(b_out, a_val);
            check(b_oe, 8'hff);
         end
         {sel_ba, en_b, en_a_n, a_drv, b_drv} = 5'b00001;
         b_val = 8'hc6;
         #1;
         check(a_out, b_val);
         check(a_oe, 8'hff);
         check(b_oe, 8'h00);
         en_a_n = 1;
         #1;
         check(a_oe, 8'h00);
         step(1);
      end
   endtask

   task t_store;
      begin
         {en_b, en_a_n, a_drv, b_drv} = 4'b0111;
         a_val = 8'h5a;
         b_val = 8'hc3;
         pulse(1, 1);
         {sel_ab, sel_ba, en_b, en_a_n, a_drv, b_drv} = 6'b111000;
         #1;
         check(b_out, 8'h5a);
         check(a_out, 8'hc3);
         step(1);
      end
   endtask

   task t_both;
      begin
         {sel_ab, sel_ba, en_b, en_a_n, a_drv, b_drv} = 6'b111110;
         a_val = 8'h11;
         pulse(1, 0);
         a_val = 8'h22;
         pulse(1, 1);
         {en_b, en_a_n, a_drv} = 3'b000;
         #1;
         check(a_out, 8'h11);
         {sel_ab, en_b, en_a_n, a_drv} = 4'b0111;
         a_val = 8'h33;
         pulse(1, 1);
         {sel_ab, en_a_n, a_drv} = 3'b100;
         #1;
         check(b_out, 8'h33);
         check(a_out, 8'h33);
         {en_b, b_drv} = 2'b01;
         b_val = 8'h44;
         pulse(0, 1);
         b_val = 8'h55;
         pulse(1, 1);
         {en_b, b_drv} = 2'b10;
         #1;
         check(b_out, 8'h44);
         check(a_out, 8'h55);
         step(1);
      end
   endtask

   task t_scan;
      begin
         {sel_ab, en_b, en_a_n, a_drv} = 4'b0111;
         load_ir(8'h82);
         a_val = 8'h6c;
         #1;
         check(test_mode, 0);
         check(b_out, 8'h6c);
         sel_ab = 1;
         load_ir(8'h0a);
         check(test_mode, 1);
         check(a_oe, 8'h00);
         check(b_oe, 8'hff);
         a_val = 8'h9e;
         pulse(1, 0);
         pat = b_out;
         tck_bit(0, 0);
         check(b_out, {pat[6:0], ^(pat & 8'hb8)});
         repeat (5) tck_bit(1, 0);
         check(test_mode, 0);
         check(b_out, 8'h44);
      end
   endtask

   task t_sig;
      begin
         load_ir(8'h0c);
         a_val = 8'h80;
         check(test_mode, 1);
         check(b_oe, 8'h00);
         tck_bit(0, 0);
         tck_bit(1, 0);
         tck_bit(0, 0);
         tck_bit(0, 0);
         check(tdo_oe, 1);
         for (i = 0; i < 8; i = i + 1) begin
            pat[i] = tdo;
            tck_bit(i == 7, 0);
         end
         // seed 00, two compress steps of 80 with taps b8
         check(pat, 8'h81);
         check(tdo_oe, 0);
         repeat (5) tck_bit(1, 0);
         check(test_mode, 0);
      end
   endtask

   initial begin
      #200000;
      errors = errors + 1;
      close_out;
   end

   initial begin
      errors = 0;
      comparisons = 0;
      {reset_n, tck, tms, tdi, clk_ab, clk_ba, sel_ab, sel_ba} = 8'b00100000;
      {en_b, en_a_n, a_drv, b_drv} = 4'b0111;
      a_val = 8'h00;
      b_val = 8'h00;
      step(2);
      reset_n = 1;
      step(3);
      t_live;
      t_store;
      t_both;
      t_scan;
      t_sig;
      close_out;
   end
endmodule // rbx_xcvr_test
